// file: common/smr_cfg.svh
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH

// System clock period and the link clock divider (half period in system cycles).
`define SMR_CLK_NS        4
`define SMR_CK_HALF       4
`define SMR_DIV_LAST      3'h7
`define SMR_DIV_RISE      3'h3
// Start-up and reinitialisation times, least times rounded up to whole cycles.
`define SMR_T_INIT1_NS    100
`define SMR_T_INIT1_CYC   ((`SMR_T_INIT1_NS + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
`define SMR_T_INIT2_TCK   5
`define SMR_T_INIT2_CYC   (`SMR_T_INIT2_TCK * 2 * `SMR_CK_HALF)
`define SMR_T_INIT3_US    200
`define SMR_T_INIT3_CYC   ((`SMR_T_INIT3_US * 1000 + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
`define SMR_T_INIT4_US    1
`define SMR_T_INIT4_CYC   ((`SMR_T_INIT4_US * 1000 + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
`define SMR_MAX_AUTO_INIT_US  10
`define SMR_MAX_AUTO_INIT_CYC ((`SMR_MAX_AUTO_INIT_US * 1000 + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
`define SMR_AUTO_INIT_CYC     ((`SMR_MAX_AUTO_INIT_US * 1000) / `SMR_CLK_NS)
`define SMR_T_ZQINIT_US   1
`define SMR_T_ZQINIT_CYC  ((`SMR_T_ZQINIT_US * 1000 + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
// Mode register addresses.
`define SMR_MA_DEV_INFO   8'h00
`define SMR_MA_FEATURE1   8'h01
`define SMR_MA_FEATURE2   8'h02
`define SMR_MA_IO_CFG     8'h03
`define SMR_MA_REFRESH    8'h04
`define SMR_MA_MAKER      8'h05
`define SMR_MA_REV1       8'h06
`define SMR_MA_REV2       8'h07
`define SMR_MA_WIDTH      8'h08
`define SMR_MA_TEST       8'h09
`define SMR_MA_IO_CAL     8'h0A
`define SMR_MA_BANK_MASK  8'h10
`define SMR_MA_RSVD_WR    8'h11
`define SMR_MA_PAT_A      8'h20
`define SMR_MA_PAT_B      8'h28
`define SMR_MA_RESET      8'h3F
// Field positions, masks and command payloads.
`define SMR_AUTO_INIT_BIT 0
`define SMR_RZQI_LSB      3
`define SMR_RZQI_OK       2'h3
`define SMR_LOW_NIBBLE    8'h0F
`define SMR_ALL_BITS      8'hFF
`define SMR_ZQ_INIT_CODE  8'hFF
`define SMR_RESET_DATA    8'h00
`define SMR_UNDEF_DATA    8'h00

`endif

// file: common/smr_pkg.sv
`default_nettype none
package smr_pkg;
    typedef enum logic [1:0] {SMR_NOP, SMR_MRW, SMR_MRR, SMR_PREA} smr_cmd_t;
    typedef enum logic [3:0] {C_OFF, C_CKE_LOW, C_IDLE3, C_RESET, C_WAIT4, C_POLL,
        C_POLL_RD, C_ZQ, C_ZQ_WAIT, C_READY, C_ISSUE, C_USER_RD, C_PWROFF} smr_ctrl_state_t;
    typedef enum logic [1:0] {R_IDLE, R_DATA, R_STRB_H, R_STRB_L} smr_rd_state_t;
endpackage : smr_pkg
`default_nettype wire

// file: common/smr_link_if.sv
`default_nettype none
interface smr_link_if;
    logic              ck;
    logic              cke;
    logic              cs_n;
    smr_pkg::smr_cmd_t cmd;
    logic [7:0]        ma;
    logic [7:0]        op;
    logic [7:0]        dq_d;
    logic              dq_oe;
    logic              dqs_d;
    logic              dqs_oe;
    logic [7:0]        dq;
    logic              dqs;

    // An undriven data bus reads as zero.
    assign dq  = dq_oe ? dq_d : 8'h00;
    assign dqs = dqs_oe ? dqs_d : 1'b0;

    modport ctrl (output ck, cke, cs_n, cmd, ma, op, input dq, dqs);
    modport mem (input ck, cke, cs_n, cmd, ma, op, output dq_d, dq_oe, dqs_d, dqs_oe);
endinterface : smr_link_if
`default_nettype wire

// file: hw/smr_mem_end.sv
`include "smr_cfg.svh"
`default_nettype none
module smr_mem_end #(
    parameter logic [2:0] REFRESH_RATE = 3'h3,
    parameter logic [7:0] MAKER_ID     = 8'h5A, // Arbitrary value.
    parameter logic [7:0] REV_ONE      = 8'h01, // Arbitrary value.
    parameter logic [7:0] REV_TWO      = 8'h02, // Arbitrary value.
    parameter logic [7:0] WIDTH_TYPE   = 8'h00,
    parameter logic [7:0] PATTERN_A    = 8'h55,
    parameter logic [7:0] PATTERN_B    = 8'hAA
) (
    input  wire logic  sys_clk_i,
    input  wire logic  reset_i,
    input  wire logic  ce_i,
    smr_link_if.mem    link,
    output logic       init_done_o,
    output logic [7:0] burst_cfg_o,
    output logic [7:0] latency_cfg_o,
    output logic [7:0] drive_cfg_o,
    output logic [7:0] cal_code_o,
    output logic [7:0] bank_mask_o,
    output logic [7:0] test_mode_o
);

    typedef struct packed {
        logic [20:0]                 sy1;
        logic [20:0]                 sy2;
        logic                        ck_prev;
        logic                        auto_init_status;
        logic [11:0]                 init_cnt;
        logic [1:0]                  rzqi;
        logic [7:0]                  mr1;
        logic [7:0]                  mr2;
        logic [7:0]                  mr3;
        logic [7:0]                  mr9;
        logic [7:0]                  mr10;
        logic [7:0]                  mr16;
        smr_pkg::smr_rd_state_t      rd;
        logic [7:0]                  dq;
        logic                        oe;
        logic                        dqs;
    } smr_mem_t;

    smr_mem_t          r;
    smr_mem_t          next_r;
    logic              ck_s;
    logic              cke_s;
    logic              cs_n_s;
    smr_pkg::smr_cmd_t cmd_s;
    logic [7:0]        ma_s;
    logic [7:0]        op_s;
    logic              rise;

    // Undefined data of write-only and reserved addresses is a fixed zero.
    function automatic logic [7:0] smr_read_value(input logic [7:0] ma, input smr_mem_t s);
        logic [7:0] v;
        v = `SMR_UNDEF_DATA;
        unique case (ma)
            `SMR_MA_DEV_INFO: v = 8'({s.rzqi, 2'h0, s.auto_init_status});
            `SMR_MA_REFRESH:  v = 8'(REFRESH_RATE);
            `SMR_MA_MAKER:    v = MAKER_ID;
            `SMR_MA_REV1:     v = REV_ONE;
            `SMR_MA_REV2:     v = REV_TWO;
            `SMR_MA_WIDTH:    v = WIDTH_TYPE;
            `SMR_MA_PAT_A:    v = PATTERN_A;
            `SMR_MA_PAT_B:    v = PATTERN_B;
            default:          v = `SMR_UNDEF_DATA;
        endcase
        return v;
    endfunction : smr_read_value

    assign {ck_s, cke_s, cs_n_s} = r.sy2[20:18];
    assign cmd_s = smr_pkg::smr_cmd_t'(r.sy2[17:16]);
    assign {ma_s, op_s} = r.sy2[15:0];
    assign rise = ck_s & ~r.ck_prev;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_r = r;
        next_r.sy1 = {link.ck, link.cke, link.cs_n, link.cmd, link.ma, link.op};
        next_r.sy2 = r.sy1;
        next_r.ck_prev = ck_s;
        if (r.auto_init_status)
        begin
            next_r.init_cnt = r.init_cnt + 12'h001;
            if (r.init_cnt == 12'(`SMR_AUTO_INIT_CYC - 1))
            begin
                next_r.auto_init_status = 1'b0;
            end
        end
        if (rise && cke_s)
        begin
            unique case (r.rd)
                smr_pkg::R_DATA:   begin next_r.dqs = 1'b1; next_r.rd = smr_pkg::R_STRB_H; end
                smr_pkg::R_STRB_H: begin next_r.dqs = 1'b0; next_r.rd = smr_pkg::R_STRB_L; end
                smr_pkg::R_STRB_L: begin next_r.oe = 1'b0; next_r.rd = smr_pkg::R_IDLE; end
                smr_pkg::R_IDLE:   begin end
            endcase
            if (!cs_n_s && cmd_s == smr_pkg::SMR_MRW)
            begin
                unique case (ma_s)
                    `SMR_MA_FEATURE1:  next_r.mr1 = op_s;
                    `SMR_MA_FEATURE2:  next_r.mr2 = op_s;
                    `SMR_MA_IO_CFG:    next_r.mr3 = op_s;
                    `SMR_MA_TEST:      next_r.mr9 = op_s;
                    `SMR_MA_IO_CAL:
                    begin
                        next_r.mr10 = op_s;
                        next_r.rzqi = `SMR_RZQI_OK;
                    end
                    `SMR_MA_BANK_MASK: next_r.mr16 = op_s;
                    `SMR_MA_RESET:
                    begin
                        next_r.auto_init_status = 1'b1;
                        next_r.init_cnt = 12'h000;
                    end
                    default:           begin end
                endcase
            end
            if (!cs_n_s && cmd_s == smr_pkg::SMR_MRR)
            begin
                next_r.dq = smr_read_value(ma_s, r);
                next_r.oe = 1'b1;
                next_r.dqs = 1'b0;
                next_r.rd = smr_pkg::R_DATA;
            end
        end
        // Outputs are only guaranteed quiet while clock enable is low.
        if (!cke_s)
        begin
            next_r.oe = 1'b0;
            next_r.dqs = 1'b0;
            next_r.rd = smr_pkg::R_IDLE;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '{rd: smr_pkg::R_IDLE, auto_init_status: 1'b1, default: '0};
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    assign link.dq_d   = r.dq;
    assign link.dq_oe  = r.oe;
    assign link.dqs_d  = r.dqs;
    assign link.dqs_oe = r.oe;
    assign init_done_o   = ~r.auto_init_status;
    assign burst_cfg_o   = r.mr1;
    assign latency_cfg_o = r.mr2;
    assign drive_cfg_o   = r.mr3;
    assign cal_code_o    = r.mr10;
    assign bank_mask_o   = r.mr16;
    assign test_mode_o   = r.mr9;

endmodule : smr_mem_end
`default_nettype wire

// file: hw/smr_ctrl_end.sv
// Overview of operation
// - Clock enable low 100 ns after supply.
// - Five stable clock periods before clock enable.
// - 200 us idle before reset command.
// - 1 us idle after reset, enable high.
// - Memory finishes auto-init within 10 us.
// - Wait 1 us after calibration before use.
// - Boot clock period between 18 and 100 ns.
// - Reinitialise from reset command, skipping start-up.
// - Clock enable low during power removal.
// - Memory outputs quiet only while enable low.
// - Mode registers via read/write commands, 8-bit address.
// - Memory honours each register's access direction.
// - Reserved bits written as zero.
// - Reserved bits of defined registers read zero.
// - Undefined reads still toggle the strobe.
// - Never write wholly reserved register addresses.
// - Writes to read-only registers are ignored.
// - Reset write after idle, optional precharge-all first.
// - Status bit zero means auto-init complete.
// - Poll status or wait maximum init time.
// - Idle intervals: enable high, no-operation only.
`include "smr_cfg.svh"
`default_nettype none
module smr_ctrl_end #(
    parameter int unsigned INIT3_CYC = `SMR_T_INIT3_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       ce_i,
    smr_link_if.ctrl        link,
    input  wire logic       start_i,
    input  wire logic       soft_reset_i,
    input  wire logic       power_off_i,
    input  wire logic       mrw_req_i,
    input  wire logic       mrr_req_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic            ready_o,
    output logic            rd_valid_o,
    output logic [7:0]      rd_data_o,
    output logic            refused_o
);

    typedef struct packed {
        smr_pkg::smr_ctrl_state_t st;
        logic [2:0]               div;
        logic                     ck;
        logic                     cke;
        logic                     cs_n;
        smr_pkg::smr_cmd_t        cmd;
        logic [7:0]               ma;
        logic [7:0]               op;
        logic [15:0]              cnt;
        logic [8:0]               sy1;
        logic [8:0]               sy2;
        logic                     dqs_prev;
        logic                     req_rd;
        logic [7:0]               req_ma;
        logic [7:0]               req_op;
        logic [7:0]               rd_data;
        logic                     rd_valid;
        logic                     ready;
        logic                     refused;
    } smr_ctrl_t;

    smr_ctrl_t r;
    smr_ctrl_t next_r;
    logic      slot;
    logic      got;

    // Write mask per address; zero marks an address that must never be written.
    function automatic logic [7:0] smr_write_mask(input logic [7:0] ma);
        logic [7:0] m;
        m = 8'h00;
        unique case (ma)
            `SMR_MA_FEATURE1, `SMR_MA_TEST, `SMR_MA_IO_CAL,
            `SMR_MA_BANK_MASK, `SMR_MA_RESET: m = `SMR_ALL_BITS;
            `SMR_MA_FEATURE2, `SMR_MA_IO_CFG: m = `SMR_LOW_NIBBLE;
            default:                          m = 8'h00;
        endcase
        return m;
    endfunction : smr_write_mask

    // Commands change as the link clock falls, half a period before the memory samples.
    assign slot = (r.div == `SMR_DIV_LAST);
    assign got  = r.sy2[8] & ~r.dqs_prev;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_r = r;
        next_r.div = r.div + 3'h1;
        next_r.ck = (next_r.div > `SMR_DIV_RISE);
        next_r.sy1 = {link.dqs, link.dq};
        next_r.sy2 = r.sy1;
        next_r.dqs_prev = r.sy2[8];
        next_r.rd_valid = 1'b0;
        next_r.refused = 1'b0;
        next_r.cnt = (r.cnt == 16'hFFFF) ? r.cnt : r.cnt + 16'h0001;
        if (got)
        begin
            next_r.rd_data = r.sy2[7:0];
        end
        if (slot)
        begin
            next_r.cs_n = 1'b1;
            next_r.cmd = smr_pkg::SMR_NOP;
        end
        unique case (r.st)
            smr_pkg::C_OFF:
            begin
                next_r.cke = 1'b0;
                if (start_i)
                begin
                    next_r.cnt = 16'h0000;
                    next_r.st = smr_pkg::C_CKE_LOW;
                end
            end
            smr_pkg::C_CKE_LOW:
            begin
                if (slot && r.cnt >= 16'(`SMR_T_INIT1_CYC)
                    && r.cnt >= 16'(`SMR_T_INIT2_CYC))
                begin
                    next_r.cke = 1'b1;
                    next_r.cnt = 16'h0000;
                    next_r.st = smr_pkg::C_IDLE3;
                end
            end
            smr_pkg::C_IDLE3:
            begin
                if (slot && r.cnt >= 16'(INIT3_CYC))
                begin
                    next_r.cs_n = 1'b0;
                    next_r.cmd = smr_pkg::SMR_PREA;
                    next_r.st = smr_pkg::C_RESET;
                end
            end
            smr_pkg::C_RESET:
            begin
                if (slot)
                begin
                    next_r.cs_n = 1'b0;
                    next_r.cmd = smr_pkg::SMR_MRW;
                    next_r.ma = `SMR_MA_RESET;
                    next_r.op = `SMR_RESET_DATA;
                    next_r.cnt = 16'h0000;
                    next_r.st = smr_pkg::C_WAIT4;
                end
            end
            smr_pkg::C_WAIT4:
            begin
                if (r.cnt >= 16'(`SMR_T_INIT4_CYC))
                begin
                    next_r.st = smr_pkg::C_POLL;
                end
            end
            smr_pkg::C_POLL:
            begin
                if (r.cnt >= 16'(`SMR_MAX_AUTO_INIT_CYC))
                begin
                    next_r.st = smr_pkg::C_ZQ;
                end
                else if (slot)
                begin
                    next_r.cs_n = 1'b0;
                    next_r.cmd = smr_pkg::SMR_MRR;
                    next_r.ma = `SMR_MA_DEV_INFO;
                    next_r.st = smr_pkg::C_POLL_RD;
                end
            end
            smr_pkg::C_POLL_RD:
            begin
                if (got && !r.sy2[`SMR_AUTO_INIT_BIT])
                begin
                    next_r.st = smr_pkg::C_ZQ;
                end
                else if (got || r.cnt >= 16'(`SMR_MAX_AUTO_INIT_CYC))
                begin
                    next_r.st = smr_pkg::C_POLL;
                end
            end
            smr_pkg::C_ZQ:
            begin
                if (slot)
                begin
                    next_r.cs_n = 1'b0;
                    next_r.cmd = smr_pkg::SMR_MRW;
                    next_r.ma = `SMR_MA_IO_CAL;
                    next_r.op = `SMR_ZQ_INIT_CODE;
                    next_r.cnt = 16'h0000;
                    next_r.st = smr_pkg::C_ZQ_WAIT;
                end
            end
            smr_pkg::C_ZQ_WAIT:
            begin
                if (r.cnt >= 16'(`SMR_T_ZQINIT_CYC))
                begin
                    next_r.ready = 1'b1;
                    next_r.st = smr_pkg::C_READY;
                end
            end
            smr_pkg::C_READY:
            begin
                if (soft_reset_i)
                begin
                    next_r.ready = 1'b0;
                    next_r.st = smr_pkg::C_RESET;
                end
                else if (power_off_i)
                begin
                    next_r.ready = 1'b0;
                    next_r.st = smr_pkg::C_PWROFF;
                end
                else if (mrw_req_i && smr_write_mask(addr_i) == 8'h00)
                begin
                    next_r.refused = 1'b1;
                end
                else if (mrw_req_i || mrr_req_i)
                begin
                    next_r.ready = 1'b0;
                    next_r.req_rd = ~mrw_req_i;
                    next_r.req_ma = addr_i;
                    next_r.req_op = wdata_i & smr_write_mask(addr_i);
                    next_r.st = smr_pkg::C_ISSUE;
                end
            end
            smr_pkg::C_ISSUE:
            begin
                if (slot)
                begin
                    next_r.cs_n = 1'b0;
                    next_r.cmd = r.req_rd ? smr_pkg::SMR_MRR : smr_pkg::SMR_MRW;
                    next_r.ma = r.req_ma;
                    next_r.op = r.req_op;
                    next_r.ready = ~r.req_rd;
                    next_r.st = r.req_rd ? smr_pkg::C_USER_RD : smr_pkg::C_READY;
                end
            end
            smr_pkg::C_USER_RD:
            begin
                if (got)
                begin
                    next_r.rd_valid = 1'b1;
                    next_r.ready = 1'b1;
                    next_r.st = smr_pkg::C_READY;
                end
            end
            smr_pkg::C_PWROFF:
            begin
                if (slot)
                begin
                    next_r.cke = 1'b0;
                end
                if (start_i && !r.cke)
                begin
                    next_r.cnt = 16'h0000;
                    next_r.st = smr_pkg::C_CKE_LOW;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            r <= '{st: smr_pkg::C_OFF, cmd: smr_pkg::SMR_NOP, cs_n: 1'b1, default: '0};
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    assign link.ck   = r.ck;
    assign link.cke  = r.cke;
    assign link.cs_n = r.cs_n;
    assign link.cmd  = r.cmd;
    assign link.ma   = r.ma;
    assign link.op   = r.op;
    assign ready_o    = r.ready;
    assign rd_valid_o = r.rd_valid;
    assign rd_data_o  = r.rd_data;
    assign refused_o  = r.refused;

endmodule : smr_ctrl_end
`default_nettype wire

// file: testbench/smr_link_assertions.sv
`default_nettype none
module smr_link_assertions #(
    parameter int unsigned INIT3_CYC = 50000
) (
    input wire logic              sys_clk_i,
    input wire logic              reset_i,
    input wire logic              ck,
    input wire logic              cke,
    input wire logic              cs_n,
    input wire smr_pkg::smr_cmd_t cmd,
    input wire logic [7:0]        ma,
    input wire logic [7:0]        op,
    input wire logic              dq_oe,
    input wire logic              dqs_d
);
    timeunit 1ns;
    timeprecision 100ps;
    // Counters saturate, so a long idle stretch never wraps into a false pass.
    logic [7:0]  low_cnt;
    logic [7:0]  ck_cnt;
    logic [31:0] cke_cnt;
    logic [15:0] quiet_cnt;
    logic        ck_q;
    logic        start;
    logic        quiet_cmd;

    // Commands count where the memory takes them, so back-to-back commands each count.
    assign start = ck && !ck_q && !cs_n;
    assign quiet_cmd = start && cmd == smr_pkg::SMR_MRW && (ma == 8'h3F || ma == 8'h0A);

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ck_q <= 1'b0;
            low_cnt <= 8'h00;
            ck_cnt <= 8'h00;
            cke_cnt <= 32'h0;
            quiet_cnt <= 16'hFFFF;
        end
        else
        begin
            ck_q <= ck;
            low_cnt <= cke ? 8'h00 : low_cnt + {7'h0, low_cnt != 8'hFF};
            ck_cnt <= cke ? 8'h00 : ck_cnt + {7'h0, ck && !ck_q && ck_cnt != 8'hFF};
            cke_cnt <= cke ? cke_cnt + {31'h0, cke_cnt != 32'hFFFFFFFF} : 32'h0;
            quiet_cnt <= quiet_cmd ? 16'h1 : quiet_cnt + {15'h0, quiet_cnt != 16'hFFFF};
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_dqs_high;
        dqs_d;
    endsequence
    sequence s_dqs_low;
        !dqs_d;
    endsequence

    property p_cke_low_time;
        $rose(cke) |-> low_cnt >= 8'h19;
    endproperty
    property p_clock_before_cke;
        $rose(cke) |-> ck_cnt >= 8'h05;
    endproperty
    property p_idle_after_cke;
        start |-> cke_cnt >= INIT3_CYC;
    endproperty
    property p_quiet_after_reset;
        start |-> quiet_cnt >= 16'h00FA;
    endproperty
    property p_cke_kept_high;
        quiet_cnt < 16'h00FA |-> cke;
    endproperty
    property p_reserved_zero;
        (!cs_n && cmd == smr_pkg::SMR_MRW && (ma == 8'h02 || ma == 8'h03)) |-> op[7:4] == 4'h0;
    endproperty
    property p_writable_only;
        (!cs_n && cmd == smr_pkg::SMR_MRW) |->
            ma inside {8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h10, 8'h3F};
    endproperty
    property p_read_strobe;
        $rose(dq_oe) |-> ##[1:12] s_dqs_high ##[1:12] s_dqs_low;
    endproperty
    property p_quiet_cke_low;
        !cke [*4] |-> !dq_oe;
    endproperty

    a_cke_low_time :
        assert property (p_cke_low_time) else $error("enable rose too early");
    a_clock_before_cke :
        assert property (p_clock_before_cke) else $error("too few clocks before enable");
    a_idle_after_cke :
        assert property (p_idle_after_cke) else $error("command before idle time");
    a_quiet_after_reset :
        assert property (p_quiet_after_reset) else $error("command too soon after reset");
    a_cke_kept_high :
        assert property (p_cke_kept_high) else $error("enable dropped after reset");
    a_reserved_zero :
        assert property (p_reserved_zero) else $error("reserved bits written nonzero");
    a_writable_only :
        assert property (p_writable_only) else $error("write to unwritable address");
    a_read_strobe :
        assert property (p_read_strobe) else $error("strobe did not toggle");
    a_quiet_cke_low :
        assert property (p_quiet_cke_low) else $error("data driven with enable low");
endmodule : smr_link_assertions
`default_nettype wire

// file: testbench/sdram_init_and_mode_regs_tb_top.sv
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("BAD %s expected %h seen %h", what, exp, got); \
        end \
    end
module sdram_init_and_mode_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned INIT3 = 100;
    int n_errors = 0;
    int tests_run = 0;
    int n_refused = 0;
    int cke_drop = 0;
    logic sys_clk, reset, start, soft_rst, pwr_off, mrw_req, mrr_req, watch_cke, ce;
    logic ready, rd_valid, refused, init_done;
    logic [7:0] addr, wdata, rd_data, v, burst, lat, drv, cal, bank, test;
    // Address in the upper byte, expected read value in the lower byte.
    logic [15:0] rd_tab [11] = '{16'h0018, 16'h0405, 16'h053C, 16'h0601, 16'h0702,
        16'h0812, 16'h2033, 16'h28CC, 16'h0100, 16'h0B00, 16'h1100};

    smr_link_if i_smr_link_if ();
    smr_ctrl_end #(.INIT3_CYC(INIT3)) i_smr_ctrl_end (.sys_clk_i(sys_clk), .reset_i(reset),
        .ce_i(ce), .link(i_smr_link_if), .start_i(start), .soft_reset_i(soft_rst),
        .power_off_i(pwr_off), .mrw_req_i(mrw_req), .mrr_req_i(mrr_req), .addr_i(addr),
        .wdata_i(wdata), .ready_o(ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
        .refused_o(refused));
    // Identity values below are arbitrary.
    smr_mem_end #(.REFRESH_RATE(3'h5), .MAKER_ID(8'h3C),
        .WIDTH_TYPE(8'h12), .PATTERN_A(8'h33), .PATTERN_B(8'hCC)) i_smr_mem_end (
        .sys_clk_i(sys_clk), .reset_i(reset), .ce_i(ce), .link(i_smr_link_if),
        .init_done_o(init_done), .burst_cfg_o(burst), .latency_cfg_o(lat),
        .drive_cfg_o(drv), .cal_code_o(cal), .bank_mask_o(bank), .test_mode_o(test));
    smr_link_assertions #(.INIT3_CYC(INIT3)) i_smr_link_assertions (.sys_clk_i(sys_clk),
        .reset_i(reset), .ck(i_smr_link_if.ck), .cke(i_smr_link_if.cke),
        .cs_n(i_smr_link_if.cs_n), .cmd(i_smr_link_if.cmd), .ma(i_smr_link_if.ma),
        .op(i_smr_link_if.op), .dq_oe(i_smr_link_if.dq_oe), .dqs_d(i_smr_link_if.dqs_d));

    ////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (refused === 1'b1)
            n_refused++;
        if (watch_cke && i_smr_link_if.cke !== 1'b1)
            cke_drop++;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wait_ready(input int limit);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < limit)
        begin
            tick();
            n++;
        end
        `CHK("ready", 1'b1, ready)
    endtask : wait_ready

    task automatic mr_write(input logic [7:0] a, input logic [7:0] d);
        tick();
        addr = a;
        wdata = d;
        mrw_req = 1'b1;
        tick();
        mrw_req = 1'b0;
        wait_ready(40);
        repeat (8) tick();
    endtask : mr_write

    // A read that never answers leaves stale data, which the ready check in wait_ready catches.
    task automatic mr_read(input logic [7:0] a, output logic [7:0] d);
        int n;
        tick();
        addr = a;
        mrr_req = 1'b1;
        tick();
        mrr_req = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 200)
        begin
            tick();
            n++;
        end
        d = rd_data;
        wait_ready(40);
    endtask : mr_read

    ////////////////////////////////////////
    initial
    begin
        {start, soft_rst, pwr_off, mrw_req, mrr_req, watch_cke} = 6'h00;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        reset = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        tick();
        start = 1'b1;
        tick();
        start = 1'b0;
        wait_ready(6000);
        `CHK("init_done", 1'b1, init_done)
        `CHK("cal_code", 8'hFF, cal)
        foreach (rd_tab[i])
        begin
            mr_read(rd_tab[i][15:8], v);
            `CHK("mr_read", rd_tab[i][7:0], v)
        end
        mr_write(8'h01, 8'hA5);
        `CHK("burst", 8'hA5, burst)
        mr_write(8'h02, 8'hF6);
        `CHK("latency", 8'h06, lat)
        mr_write(8'h03, 8'hE2);
        `CHK("drive", 8'h02, drv)
        mr_write(8'h09, 8'h5A);
        `CHK("test", 8'h5A, test)
        mr_write(8'h10, 8'hC3);
        `CHK("bank", 8'hC3, bank)
        mr_write(8'h00, 8'hFF);
        mr_write(8'h11, 8'h77);
        mr_write(8'h3E, 8'h01);
        mr_read(8'h00, v);
        `CHK("mr0_kept", 8'h18, v)
        `CHK("refused", 3, n_refused)
        ce = 1'b0;
        mr_write(8'h01, 8'h3C);
        ce = 1'b1;
        `CHK("frozen", 8'hA5, burst)
        tick();
        watch_cke = 1'b1;
        soft_rst = 1'b1;
        tick();
        soft_rst = 1'b0;
        tick();
        `CHK("ready_drop", 1'b0, ready)
        wait_ready(6000);
        watch_cke = 1'b0;
        `CHK("cke_kept", 0, cke_drop)
        `CHK("init_done", 1'b1, init_done)
        tick();
        pwr_off = 1'b1;
        tick();
        pwr_off = 1'b0;
        repeat (20) tick();
        `CHK("cke_off", 1'b0, i_smr_link_if.cke)
        `CHK("dq_oe_off", 1'b0, i_smr_link_if.dq_oe)
        end_sim();
    end

    // Both boots and the register traffic need about 6300 cycles.
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end
endmodule : sdram_init_and_mode_regs_tb_top
`default_nettype wire
